// [include/eeprom_defines.svh]
// Constants of the serial EEPROM slave, with its contract list
//
// Contract
// - Sample data on clock rise; master changes low
// - Select code: 4-bit type, 3-bit chip field
// - Answer only on type and pin match
// - Big parts carry address bits in chip field
// - Select bit eight: one read, zero write
// - Match acks ninth bit; mismatch goes standby
// - Write select, then address byte, then data
// - Stop in tenth slot alone starts write
// - Busy write cycle ignores the whole bus
// - Protect seen before data means no ack
// - Page write holds one to 16 bytes
// - Page write increments low four bits only
// - Protected page write acks no data byte
// - Polling select acked only when not busy
// - Reads ignore protect; counter advances per byte
// - Random read: dummy write, restart, read
// - Current read returns counter byte, then increments
// - Master ack requests next consecutive byte
// - Read counter wraps past top to zero
// - No master ack ends read, standby
// - Start and Stop are data edges, clock high
// - Protect still acks select and address bytes
`ifndef EEPROM_DEFINES_SVH
`define EEPROM_DEFINES_SVH
// Arbitrary type code, not tied to any real part
`define DEVICE_TYPE_DEFAULT 4'h5
`define CAPACITY_KBIT_DEFAULT 16
`define ADDR_BITS_MAX 11
`define MEM_DEPTH 2048
`define PAGE_BITS 4
`define LAST_BIT_CNT 4'h7
`define ACK_BIT_CNT 4'h8
`define STOP_SLOT_CNT 4'h1
`define FIFO_DEPTH 32
`define CLK_PERIOD_NS 10
`define WRITE_TIME_NS 5000
`define WRITE_CYCLES ((`WRITE_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

// [include/eeprom_pkg.sv]
// Types of the serial EEPROM slave
package eeprom_pkg;
   typedef enum logic [4:0] {
      ST_IDLE = 5'h01,
      ST_SEL = 5'h02,
      ST_ADDR = 5'h04,
      ST_WRITE = 5'h08,
      ST_READ = 5'h10
   } state_t;
endpackage

// [rtl/i2c_serial_eeprom_slave.sv]
// Serial EEPROM slave engine with its pending-write FIFO
`timescale 1ns/100ps
`default_nettype none
`include "eeprom_defines.svh"

module eeprom_word_fifo #(
   parameter int WIDTH = 19,
   parameter int DEPTH = 32
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire logic flush,
   // Fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // Drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int PW = $clog2(DEPTH);
   logic [WIDTH-1:0] store [DEPTH];
   logic [PW:0] wr_ptr_reg;
   logic [PW:0] rd_ptr_reg;
   wire push = in_valid && in_ready;
   wire pop = out_valid && out_ready;
   assign in_ready = (wr_ptr_reg ^ rd_ptr_reg) != {1'b1, {PW{1'b0}}};
   assign out_valid = wr_ptr_reg != rd_ptr_reg;
   assign out_data = store[rd_ptr_reg[PW-1:0]];
   always_ff @(posedge ref_clk) begin
      if (push)
         store[wr_ptr_reg[PW-1:0]] <= in_data;
   end
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
      end else if (flush) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
      end else begin
         wr_ptr_reg <= wr_ptr_reg + (PW+1)'(push);
         rd_ptr_reg <= rd_ptr_reg + (PW+1)'(pop);
      end
   end
endmodule

module i2c_serial_eeprom_slave #(
   parameter int CAPACITY_KBIT = `CAPACITY_KBIT_DEFAULT,
   // Arbitrary value, not tied to any real part
   parameter logic [3:0] DEVICE_TYPE = `DEVICE_TYPE_DEFAULT
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic sys_rst,
   // Serial bus pins
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe_n,
   // Straps and protection
   input wire logic chip_select_pin_low,
   input wire logic chip_select_pin_mid,
   input wire logic chip_select_pin_high,
   input wire logic write_protect_input,
   // Status
   output logic write_busy
);
   // Address width and chip-field bits used as address
   localparam int AW = $clog2(CAPACITY_KBIT * 128);
   localparam int NSEL = (AW > 8) ? AW - 8 : 0;
   localparam logic [10:0] AMASK = 11'((1 << AW) - 1);
   localparam logic [2:0] HI_MASK = 3'((1 << NSEL) - 1);
   localparam int WCYC = `WRITE_CYCLES;

   function automatic logic [10:0] seq_next(input logic [10:0] a);
      seq_next = (a + 11'h001) & AMASK;
   endfunction

   logic [7:0] mem [`MEM_DEPTH];

   // Two-flop synchronisers, then a third stage for edges
   logic scl_meta, scl_sync, scl_prev, sda_meta, sda_sync, sda_prev;
   logic [3:0] pin_meta, pin_sync;
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         {scl_meta, scl_sync, scl_prev} <= 3'h7;
         {sda_meta, sda_sync, sda_prev} <= 3'h7;
         pin_meta <= 4'h0;
         pin_sync <= 4'h0;
      end else begin
         {scl_meta, scl_sync, scl_prev} <= {scl_in, scl_meta, scl_sync};
         {sda_meta, sda_sync, sda_prev} <= {sda_in, sda_meta, sda_sync};
         pin_meta <= {write_protect_input, chip_select_pin_high, chip_select_pin_mid, chip_select_pin_low};
         pin_sync <= pin_meta;
      end
   end
   wire [2:0] cs_pins = pin_sync[2:0];
   wire wp_pin = pin_sync[3];

   eeprom_pkg::state_t state_reg, state_next;
   logic [3:0] cnt_reg, cnt_next;
   logic [7:0] shift_reg, shift_next;
   logic [7:0] rd_byte_reg, rd_byte_next;
   logic [10:0] addr_reg, addr_next;
   logic [2:0] sel_hi_reg, sel_hi_next;
   logic ack_reg, ack_next;
   logic data_seen_reg, data_seen_next;
   logic wp_seen_reg, wp_seen_next;
   logic oe_n_reg, oe_n_next;
   logic busy_reg, busy_next;
   logic [$clog2(WCYC+1)-1:0] timer_reg, timer_next;

   // Bus events are masked while the write cycle runs
   wire scl_rise = scl_sync && !scl_prev && !busy_reg;
   wire scl_fall = !scl_sync && scl_prev && !busy_reg;
   wire start_det = scl_sync && scl_prev && !sda_sync && sda_prev && !busy_reg;
   wire stop_det = scl_sync && scl_prev && sda_sync && !sda_prev && !busy_reg;
   wire [7:0] byte_in = {shift_reg[6:0], sda_sync};
   wire byte_done = scl_rise && cnt_reg == `LAST_BIT_CNT;
   wire ack_rise = scl_rise && cnt_reg == `ACK_BIT_CNT;
   wire in_sel = state_reg == eeprom_pkg::ST_SEL;
   wire in_write = state_reg == eeprom_pkg::ST_WRITE;
   wire in_read = state_reg == eeprom_pkg::ST_READ;
   // Type nibble, then unmasked chip bits against straps
   wire sel_match = byte_in[7:4] == DEVICE_TYPE && ((byte_in[3:1] ^ cs_pins) & ~HI_MASK) == 3'h0;
   wire stop_ok = stop_det && in_write && data_seen_reg && cnt_reg == `STOP_SLOT_CNT;
   wire [10:0] page_addr = {addr_reg[10:4], addr_reg[3:0] + 4'h1};

   // Pending page words; a full FIFO turns into a data NoAck
   logic fifo_in_ready, fifo_out_valid;
   logic [18:0] fifo_out;
   wire data_ok = !wp_seen_reg && fifo_in_ready;
   wire push = byte_done && in_write && data_ok;
   wire fifo_flush = (start_det || stop_det) && !stop_ok;
   eeprom_word_fifo #(.WIDTH(19), .DEPTH(`FIFO_DEPTH)) u_fifo (
      .ref_clk(ref_clk),
      .sys_rst(sys_rst),
      .flush(fifo_flush),
      .in_valid(push),
      .in_ready(fifo_in_ready),
      .in_data({addr_reg & AMASK, byte_in}),
      .out_valid(fifo_out_valid),
      .out_ready(busy_reg),
      .out_data(fifo_out)
   );

   // Words commit in order, so a page roll-over overwrites earlier bytes
   always_ff @(posedge ref_clk) begin
      if (busy_reg && fifo_out_valid)
         mem[fifo_out[18:8]] <= fifo_out[7:0];
   end

   always_comb begin
      state_next = state_reg;
      cnt_next = cnt_reg;
      shift_next = shift_reg;
      rd_byte_next = rd_byte_reg;
      addr_next = addr_reg;
      sel_hi_next = sel_hi_reg;
      ack_next = ack_reg;
      data_seen_next = data_seen_reg;
      oe_n_next = oe_n_reg;
      busy_next = busy_reg;
      timer_next = timer_reg;
      // Protect is latched from Start through the address byte
      if (start_det)
         wp_seen_next = wp_pin;
      else
         wp_seen_next = wp_seen_reg || (wp_pin && (in_sel || state_reg == eeprom_pkg::ST_ADDR));
      if (busy_reg) begin
         if (timer_reg != '0)
            timer_next = timer_reg - 1'b1;
         else if (!fifo_out_valid)
            busy_next = 1'b0;
      end
      if (stop_ok) begin
         busy_next = 1'b1;
         timer_next = ($bits(timer_reg))'(WCYC - 1);
         state_next = eeprom_pkg::ST_IDLE;
         oe_n_next = 1'b1;
      end else if (start_det) begin
         state_next = eeprom_pkg::ST_SEL;
         cnt_next = 4'h0;
         data_seen_next = 1'b0;
         oe_n_next = 1'b1;
      end else if (stop_det) begin
         state_next = eeprom_pkg::ST_IDLE;
         oe_n_next = 1'b1;
      end else if (state_reg != eeprom_pkg::ST_IDLE) begin
         if (scl_rise && cnt_reg < `ACK_BIT_CNT) begin
            shift_next = byte_in;
            cnt_next = cnt_reg + 4'h1;
         end
         if (byte_done) begin
            case (state_reg)
               eeprom_pkg::ST_SEL: begin
                  ack_next = sel_match;
                  sel_hi_next = byte_in[3:1] & HI_MASK;
                  if (!sel_match)
                     state_next = eeprom_pkg::ST_IDLE;
               end
               eeprom_pkg::ST_ADDR: ack_next = 1'b1;
               eeprom_pkg::ST_WRITE: begin
                  ack_next = data_ok;
                  if (data_ok)
                     addr_next = page_addr;
               end
               default: ack_next = 1'b0;
            endcase
         end
         if (ack_rise) begin
            cnt_next = 4'h0;
            case (state_reg)
               eeprom_pkg::ST_SEL: begin
                  if (shift_reg[0]) begin
                     // Current or random read output
                     state_next = eeprom_pkg::ST_READ;
                     rd_byte_next = mem[addr_reg];
                     addr_next = seq_next(addr_reg);
                  end else
                     state_next = eeprom_pkg::ST_ADDR;
               end
               eeprom_pkg::ST_ADDR: begin
                  state_next = eeprom_pkg::ST_WRITE;
                  addr_next = {sel_hi_reg, shift_reg} & AMASK;
               end
               eeprom_pkg::ST_WRITE: data_seen_next = 1'b1;
               eeprom_pkg::ST_READ: begin
                  if (sda_sync)
                     state_next = eeprom_pkg::ST_IDLE;
                  else begin
                     rd_byte_next = mem[addr_reg];
                     addr_next = seq_next(addr_reg);
                  end
               end
               default: state_next = eeprom_pkg::ST_IDLE;
            endcase
         end
         // Drive changes only on clock low phases
         if (scl_fall) begin
            if (cnt_reg == `ACK_BIT_CNT)
               oe_n_next = !(ack_reg && !in_read);
            else if (in_read)
               oe_n_next = rd_byte_reg[3'(`LAST_BIT_CNT - cnt_reg)];
            else
               oe_n_next = 1'b1;
         end
      end else
         oe_n_next = 1'b1;
   end

   // Reset into standby with the counter at zero
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         state_reg <= eeprom_pkg::ST_IDLE;
         {cnt_reg, shift_reg, rd_byte_reg} <= 20'h00000;
         {addr_reg, sel_hi_reg} <= 14'h0000;
         {ack_reg, data_seen_reg, wp_seen_reg, busy_reg} <= 4'h0;
         oe_n_reg <= 1'b1;
         timer_reg <= '0;
      end else begin
         state_reg <= state_next;
         {cnt_reg, shift_reg, rd_byte_reg} <= {cnt_next, shift_next, rd_byte_next};
         {addr_reg, sel_hi_reg} <= {addr_next, sel_hi_next};
         {ack_reg, data_seen_reg, wp_seen_reg, busy_reg} <= {ack_next, data_seen_next, wp_seen_next, busy_next};
         oe_n_reg <= oe_n_next;
         timer_reg <= timer_next;
      end
   end

   assign sda_out = 1'b0;
   assign sda_oe_n = oe_n_reg;
   assign write_busy = busy_reg;

   // Length of the running write cycle; read only by the checks below
   logic [$clog2(WCYC+1):0] busy_len_reg;
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst)
         busy_len_reg <= '0;
      else if (busy_reg)
         busy_len_reg <= busy_len_reg + 1'b1;
      else
         busy_len_reg <= '0;
   end

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (sys_rst);

   sequence s_sel_done;
      byte_done && in_sel && !stop_det && !start_det;
   endsequence
   sequence s_read_ack;
      ack_rise && in_read && !stop_det && !start_det;
   endsequence

   a_start_release: assert property (start_det && !stop_ok |=> oe_n_reg && in_sel)
      else $error("start did not enter select phase");
   a_sel_mismatch: assert property (s_sel_done ##0 !sel_match |=> state_reg == eeprom_pkg::ST_IDLE)
      else $error("mismatched select not dropped");
   // Select, address, write-cycle, protect, page and read checks
   a_sel_ack_flag: assert property (s_sel_done ##0 sel_match |=> ack_reg)
      else $error("matching select not flagged for acknowledge");
   a_sel_ack_drive: assert property (scl_fall && in_sel && cnt_reg == `ACK_BIT_CNT && ack_reg |=> !oe_n_reg)
      else $error("matching select not acknowledged");
   a_write_entry: assert property (ack_rise && in_sel && !shift_reg[0] |=> state_reg == eeprom_pkg::ST_ADDR)
      else $error("write select did not expect address");
   a_addr_entry: assert property (ack_rise && state_reg == eeprom_pkg::ST_ADDR |=> in_write)
      else $error("address byte did not lead to data phase");
   a_addr_ack: assert property (byte_done && state_reg == eeprom_pkg::ST_ADDR |=> ack_reg)
      else $error("address byte not acknowledged");
   a_stop_trigger: assert property (stop_ok |=> busy_reg ##1 busy_reg [*8])
      else $error("valid stop did not start write cycle");
   a_busy_quiet: assert property (busy_reg && $past(busy_reg) |-> oe_n_reg && state_reg == eeprom_pkg::ST_IDLE)
      else $error("bus touched during write cycle");
   a_protect_nack: assert property (byte_done && in_write && wp_seen_reg |=> !ack_reg)
      else $error("protected data byte acknowledged");
   a_page_wrap: assert property (push && !start_det && !stop_det
      |=> addr_reg[10:4] == $past(addr_reg[10:4]) && addr_reg[3:0] == $past(addr_reg[3:0]) + 4'h1)
      else $error("page counter moved wrongly");
   a_read_stop: assert property (s_read_ack ##0 sda_sync |=> state_reg == eeprom_pkg::ST_IDLE)
      else $error("read not ended on master noack");
   a_read_advance: assert property (s_read_ack ##0 !sda_sync |=> addr_reg == seq_next($past(addr_reg)))
      else $error("read counter did not advance");
   // Data, protection, write cycle and read checks
   a_data_ack: assert property (byte_done && in_write && !wp_seen_reg && fifo_in_ready |=> ack_reg)
      else $error("open data byte not acknowledged");
   a_protect_latch: assert property (wp_pin && (in_sel || start_det) |=> wp_seen_reg)
      else $error("protect level not latched");
   a_protect_hold: assert property (wp_seen_reg && !start_det |=> wp_seen_reg)
      else $error("protect latch dropped before next start");
   a_stray_stop: assert property (stop_det && !stop_ok |=> !busy_reg)
      else $error("misplaced stop started write cycle");
   a_write_time: assert property ($fell(busy_reg) |-> busy_len_reg >= WCYC)
      else $error("write cycle ended early");
   a_fifo_drain: assert property ($fell(busy_reg) |-> !fifo_out_valid)
      else $error("write cycle ended with bytes pending");
   a_read_release: assert property (scl_fall && in_read && cnt_reg == `ACK_BIT_CNT |=> oe_n_reg)
      else $error("data line held in master ack slot");
   a_cur_read: assert property (ack_rise && in_sel && shift_reg[0] |=>
      in_read && addr_reg == seq_next($past(addr_reg)))
      else $error("read select did not load and advance");
endmodule
`default_nettype wire

// [test/i2c_bus_master_model.sv]
// Behavioural bus master that clocks the serial link
`timescale 1ns/100ps
`default_nettype none
module i2c_bus_master_model (
   // Clock
   input wire logic ref_clk,
   // Serial link, open drain data with pull-up
   input wire logic sda_line,
   output logic scl,
   output logic sda_drv
);
   initial begin
      scl = 1'h1;
      sda_drv = 1'h1;
   end
   // Link clock stands high between frames; each clock phase is 8 ref_clk cycles, in steps of 4
   task automatic hold(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask
   task automatic start();
      hold(4);
      sda_drv = 1'h1;
      hold(4);
      scl = 1'h1;
      hold(4);
      sda_drv = 1'h0;
      hold(4);
      scl = 1'h0;
   endtask
   task automatic stop();
      hold(4);
      sda_drv = 1'h0;
      hold(4);
      scl = 1'h1;
      hold(4);
      sda_drv = 1'h1;
      hold(4);
   endtask
   // Data moves well inside the low phase so no rise sees it change
   task automatic bit_io(input logic b, output logic r);
      hold(4);
      sda_drv = b;
      hold(4);
      scl = 1'h1;
      hold(4);
      r = sda_line;
      hold(4);
      scl = 1'h0;
   endtask
   task automatic send(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_io(d[i], r);
      end
      bit_io(1'h1, r);
      ack = ~r;
   endtask
   task automatic recv(input logic more, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_io(1'h1, d[i]);
      end
      bit_io(~more, r);
   endtask
endmodule
`default_nettype wire

// [test/test_i2c_serial_eeprom_slave.sv]
// Self-checking bench for the serial EEPROM slave
`timescale 1ns/100ps
`default_nettype none
module test_i2c_serial_eeprom_slave;
   // Arbitrary value, not tied to any real part
   localparam logic [3:0] DEV_TYPE = 4'h9;
   logic ref_clk, sys_rst, cs_low, cs_mid, cs_high, wp;
   logic sda_out, sda_oe_n, write_busy, scl, sda_drv, a;
   logic [7:0] d;
   int err_total, compares, cycles;
   wire sda_wire;
   // Wired-AND of master, device and pull-up
   assign sda_wire = sda_drv & (sda_oe_n | sda_out);
   i2c_serial_eeprom_slave #(.CAPACITY_KBIT(4), .DEVICE_TYPE(DEV_TYPE)) DUT (
      .ref_clk(ref_clk), .sys_rst(sys_rst), .scl_in(scl), .sda_in(sda_wire), .sda_out(sda_out),
      .sda_oe_n(sda_oe_n), .chip_select_pin_low(cs_low), .chip_select_pin_mid(cs_mid),
      .chip_select_pin_high(cs_high), .write_protect_input(wp), .write_busy(write_busy));
   i2c_bus_master_model bus (.ref_clk(ref_clk), .sda_line(sda_wire), .scl(scl), .sda_drv(sda_drv));
   always #5 ref_clk = ~ref_clk;
   function automatic logic [7:0] code(input logic a8, input logic rw);
      return {DEV_TYPE, cs_high, cs_mid, a8, rw};
   endfunction
   task automatic test_done();
      if (err_total == 0 && compares > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp) begin
         err_total++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic set_addr(input logic [8:0] addr);
      bus.start();
      bus.send(code(addr[8], 1'h0), a);
      chk({7'h00, a}, 8'h01);
      bus.send(addr[7:0], a);
      chk({7'h00, a}, 8'h01);
   endtask
   task automatic write_bytes(input logic [8:0] addr, input logic [7:0] q[$], input logic ack_exp);
      set_addr(addr);
      foreach (q[i]) begin
         bus.send(q[i], a);
         chk({7'h00, a}, {7'h00, ack_exp});
      end
      bus.stop();
   endtask
   // Polls with a bounded count; the first poll must be refused when check is set
   task automatic wait_ready(input logic check);
      bus.hold(8);
      if (check) chk({7'h00, write_busy}, 8'h01);
      a = 1'h0;
      for (int n = 0; n < 40 && a !== 1'h1; n++) begin
         bus.start();
         bus.send(code(1'h0, 1'h0), a);
         bus.stop();
         if (check && n == 0) chk({7'h00, a}, 8'h00);
      end
      chk({7'h00, a}, 8'h01);
   endtask
   task automatic recv_seq(input logic [7:0] q[$]);
      foreach (q[i]) begin
         bus.recv(i < q.size() - 1, d);
         chk(d, q[i]);
      end
      bus.stop();
      chk({7'h00, sda_oe_n}, 8'h01);
   endtask
   task automatic read_at(input logic [8:0] addr, input logic [7:0] q[$]);
      set_addr(addr);
      bus.start();
      bus.send(code(addr[8], 1'h1), a);
      chk({7'h00, a}, 8'h01);
      recv_seq(q);
   endtask
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 40000) begin
         err_total++;
         test_done();
      end
   end
   initial begin
      ref_clk = 1'h0;
      sys_rst = 1'h1;
      cs_low = 1'h1;
      cs_mid = 1'h1;
      cs_high = 1'h0;
      wp = 1'h0;
      err_total = 0;
      compares = 0;
      cycles = 0;
      repeat (20) @(posedge ref_clk);
      #1;
      sys_rst = 1'h0;
      chk({6'h00, sda_oe_n, write_busy}, 8'h02);
      // Wrong type, then wrong middle strap
      bus.start();
      bus.send({~DEV_TYPE, 4'h4}, a);
      chk({7'h00, a}, 8'h00);
      bus.stop();
      bus.start();
      bus.send(code(1'h0, 1'h0) ^ 8'h04, a);
      chk({7'h00, a}, 8'h00);
      bus.stop();
      write_bytes(9'h000, '{8'h5a}, 1'h1);
      wait_ready(1'h1);
      // Three bytes from 1feh roll over to the start of the page
      write_bytes(9'h1fe, '{8'ha1, 8'ha2, 8'ha3}, 1'h1);
      wait_ready(1'h1);
      // Stop before any data byte starts no write cycle
      set_addr(9'h0f0);
      bus.stop();
      bus.hold(8);
      chk({7'h00, write_busy}, 8'h00);
      wp = 1'h1;
      write_bytes(9'h000, '{8'hc3}, 1'h0);
      wait_ready(1'h0);
      // Reads below run with protection still high
      read_at(9'h1fe, '{8'ha1});
      bus.start();
      bus.send(code(1'h0, 1'h1), a);
      chk({7'h00, a}, 8'h01);
      recv_seq('{8'ha2, 8'h5a});
      read_at(9'h1f0, '{8'ha3});
      read_at(9'h000, '{8'h5a});
      chk({7'h00, write_busy}, 8'h00);
      test_done();
   end
endmodule
`default_nettype wire
